// [tma_count_unit.sv]
// timer a count unit: 16-bit reloadable counter with timer, event and one-shot modes behind apb.
// assumes pins are asynchronous and are synchronised here; overflow inputs come from same-clock timers.
// Functional notes
// - independent 16-bit counter per instance
// - mode from mode bits 1 and 0
// - one-shot counting halts at zero
// - timer source: f1, f8, f32, fc32
// - timer counts down, reloads on underflow
// - underflow every n+1 source periods
// - count start flag runs or halts counting
// - timer mode: interrupt on underflow
// - write while halted: reload and counter
// - write while running: reload only
// - read returns live counter contents
// - gate: input pin level starts/stops counting
// - pulse output toggles on timer underflow
// - two-phase only on instances two to four; no decoder is built here, only a status bit that flags it from instance two up
// - event source: pin edge or overflow
// - direction by software or output pin
// - event mode reloads on wrap unless free-run
// - up period ffff-n+1, down n+1
// - event mode: interrupt on any wrap
// - free-run wraps without reload
// - pulse output toggles on event wrap
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/100ps
module tma_count_unit #(
  parameter int INST_ID = 0  // position of this timer in the set
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_input_pin,
  input wire logic sub_clock_pin,
  input wire logic companion_b_timer_ovf,
  input wire logic neighbour_a_timer_ovf,
  input wire logic pulse_output_pin_in,
  output logic pulse_output_pin_out,
  output logic pulse_output_pin_oe,
  output logic irq_req
);
  import tma_pkg::*;

  // software visible state
  logic [15:0] counter;  // live count
  logic [15:0] reload;  // reload register
  logic [TMA_MODE_W-1:0] mode_reg;  // mode and select bits
  logic start;  // count start flag
  logic sw_up;  // software direction
  logic halted;  // one-shot reached zero
  logic pulse_lvl;  // toggle output level

  // synchronisers: first stage feeds only the second
  logic cin_s1;  // count input, first stage
  logic cin_s2;  // count input, settled
  logic cin_prev;  // count input, a cycle older
  logic sub_s1;  // sub-clock, first stage
  logic sub_s2;  // sub-clock, settled
  logic sub_prev;  // sub-clock, a cycle older
  logic pin_s1;  // shared pin, first stage
  logic pin_s2;  // shared pin, settled

  // decoded fields
  logic [1:0] op_mode;  // operating mode
  logic pulse_en;  // pulse output on
  logic gate_en;  // gate function on
  logic gate_lvl;  // level that opens the gate
  logic edge_rise;  // event edge choice
  logic dir_pin;  // direction from shared pin
  logic free_run;  // no reload on wrap
  logic [1:0] clk_sel;  // internal source
  logic [1:0] evt_src;  // event source
  assign op_mode = mode_reg[TMA_MODE_LSB +: 2];
  assign pulse_en = mode_reg[TMA_PULSE_EN_BIT];
  assign gate_en = mode_reg[TMA_GATE_EN_BIT];
  assign gate_lvl = mode_reg[TMA_GATE_LVL_BIT];
  assign edge_rise = mode_reg[TMA_EDGE_RISE_BIT];
  assign dir_pin = mode_reg[TMA_DIR_PIN_BIT];
  assign free_run = mode_reg[TMA_FREE_RUN_BIT];
  assign clk_sel = mode_reg[TMA_CLK_SEL_LSB +: 2];
  assign evt_src = mode_reg[TMA_EVT_SRC_LSB +: 2];

  // apb strobes
  logic acc_first;  // first access cycle
  logic wr_en;  // write completes at this edge
  logic rd_first;  // read snapshot at this edge
  logic val_wr;  // completing value write
  logic addr_ok;  // address is mapped
  assign acc_first = psel && penable && !pready;
  assign val_wr = wr_en && (paddr == TMA_OFF_VALUE);
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_first = acc_first && !pwrite;
  assign addr_ok = (paddr == TMA_OFF_VALUE) || (paddr == TMA_OFF_MODE) ||
                   (paddr == TMA_OFF_CTRL) || (paddr == TMA_OFF_STAT);

  // two-phase capability is fixed by position in the set; the two-phase decoder itself is not built here
  logic two_phase_cap;
  assign two_phase_cap = (INST_ID >= TMA_TWO_PHASE_MIN_INST);

  // pin synchronisers, two flops each before any logic looks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cin_s1 <= 1'b0;
      cin_s2 <= 1'b0;
      cin_prev <= 1'b0;
      sub_s1 <= 1'b0;
      sub_s2 <= 1'b0;
      sub_prev <= 1'b0;
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end else begin
      cin_s1 <= count_input_pin;
      cin_s2 <= cin_s1;
      cin_prev <= cin_s2;
      sub_s1 <= sub_clock_pin;
      sub_s2 <= sub_s1;
      sub_prev <= sub_s2;
      pin_s1 <= pulse_output_pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // internal count source from the prescaler
  logic int_tick;
  logic sub_tick;
  assign sub_tick = sub_s2 && !sub_prev;
  tma_prescale u_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .sub_tick(sub_tick),
    .sel(clk_sel),
    .tick(int_tick)
  );

  // event source selection
  logic pin_edge;  // selected pin edge seen
  logic evt_tick;  // one event this cycle
  assign pin_edge = edge_rise ? (cin_s2 && !cin_prev) : (!cin_s2 && cin_prev);
  always_comb begin
    unique case (evt_src)
      TMA_ES_PIN: evt_tick = pin_edge;
      TMA_ES_COMP_B: evt_tick = companion_b_timer_ovf;
      TMA_ES_NEIGH_A: evt_tick = neighbour_a_timer_ovf;
      default: evt_tick = 1'b0;  // reserved source counts nothing
    endcase
  end

  // direction: software bit or the output pin used as an input
  logic count_up;
  assign count_up = dir_pin ? pin_s2 : sw_up;

  // gate lets the count input level run or stop timer counting
  logic gate_ok;
  assign gate_ok = !gate_en || (cin_s2 == gate_lvl);

  // one count step this cycle, per mode
  logic step;
  always_comb begin
    unique case (op_mode)
      TMA_MD_TIMER: step = start && int_tick && gate_ok;
      TMA_MD_EVENT: step = start && evt_tick;
      TMA_MD_ONESHOT: step = start && int_tick && !halted;
      TMA_MD_PWM: step = 1'b0;  // pulse width modulation is not built in this unit
    endcase
  end

  // wrap detection: up counts past ffff, down counts past zero
  logic up_step;  // this step counts up
  logic wrap;  // step passes an end point
  assign up_step = (op_mode == TMA_MD_EVENT) && count_up;
  assign wrap = step && (up_step ? (counter == TMA_CNT_MAX) : (counter == TMA_CNT_ZERO));

  // counter update; write while halted loads it too, a write while running leaves it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter <= TMA_CNT_RST;
    end else if (wr_en && (paddr == TMA_OFF_VALUE) && !start) begin
      counter <= pwdata[15:0];
    end else if (wrap && !(op_mode == TMA_MD_EVENT && free_run)) begin
      counter <= reload;
    end else if (step && up_step) begin
      counter <= counter + 16'h0001;  // wraps from ffff to 0000 when free-running
    end else if (step) begin
      counter <= counter - 16'h0001;
    end
  end

  // reload register follows every value write; running counter picks it up at the next wrap, except in free-running event mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload <= TMA_CNT_RST;
    end else if (wr_en && (paddr == TMA_OFF_VALUE)) begin
      reload <= pwdata[15:0];
    end
  end

  // one-shot halts when the count reaches zero; restarting needs a new start or value write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted <= 1'b0;
    end else if (op_mode != TMA_MD_ONESHOT) begin
      halted <= 1'b0;
    end else if (step && (counter == 16'h0001)) begin
      halted <= 1'b1;
    end else if (wr_en && (paddr == TMA_OFF_VALUE || paddr == TMA_OFF_CTRL)) begin
      halted <= 1'b0;
    end
  end

  // mode and control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= TMA_MODE_RST;
      start <= 1'b0;
      sw_up <= 1'b0;
    end else if (wr_en) begin
      if (paddr == TMA_OFF_MODE) begin
        mode_reg <= pwdata[TMA_MODE_W-1:0];
      end
      if (paddr == TMA_OFF_CTRL) begin
        start <= pwdata[TMA_START_BIT];
        sw_up <= pwdata[TMA_UP_BIT];
      end
    end
  end

  // interrupt request is a one-cycle pulse per wrap in timer or event mode; a controller outside latches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= wrap && (op_mode == TMA_MD_TIMER || op_mode == TMA_MD_EVENT);
    end
  end

  // pulse output toggles on wrap in timer or event mode; the pin is released when it serves as a direction input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_lvl <= 1'b0;
      pulse_output_pin_out <= 1'b0;
      pulse_output_pin_oe <= 1'b0;
    end else begin
      if (!pulse_en) begin
        pulse_lvl <= 1'b0;
      end else if (wrap && (op_mode == TMA_MD_TIMER || op_mode == TMA_MD_EVENT)) begin
        pulse_lvl <= !pulse_lvl;
      end
      pulse_output_pin_out <= pulse_lvl;
      pulse_output_pin_oe <= pulse_en && !(op_mode == TMA_MD_EVENT && dir_pin);
    end
  end

  // apb slave: one wait state, read data snapshot taken in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= TMA_WORD_ZERO;
    end else begin
      pready <= acc_first;
      pslverr <= acc_first && !addr_ok;
      if (rd_first) begin
        prdata <= TMA_WORD_ZERO;
        unique case (1'b1)
          paddr == TMA_OFF_VALUE: prdata[15:0] <= counter;
          paddr == TMA_OFF_MODE: prdata[TMA_MODE_W-1:0] <= mode_reg;
          paddr == TMA_OFF_CTRL: prdata[TMA_UP_BIT:TMA_START_BIT] <= {sw_up, start};
          paddr == TMA_OFF_STAT: prdata[TMA_ST_TWOPH_BIT:TMA_ST_PULSE_BIT] <=
                                 {two_phase_cap, halted, step, pulse_lvl};
          default: prdata <= TMA_WORD_ZERO;  // unmapped reads as zero with an error
        endcase
      end
    end
  end

  // checks on the guarded behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // one completing write to the value register
  sequence value_write_s;
    val_wr;
  endsequence

  // a timer step taken from zero
  sequence timer_underflow_s;
    (op_mode == TMA_MD_TIMER) && step && (counter == TMA_CNT_ZERO);
  endsequence

  // underflow loads the reload value
  timer_reload_a: assert property ((timer_underflow_s and !val_wr) |=> counter == $past(reload))
    else $error("timer underflow did not reload");

  // request is one pulse unless the next step wraps too
  timer_irq_a: assert property (timer_underflow_s |=> irq_req ##1 (!irq_req || $past(wrap)))
    else $error("no interrupt pulse on timer underflow");

  // a plain timer step moves down by one
  timer_down_a: assert property ((op_mode == TMA_MD_TIMER) && step && !wrap && !val_wr
                                 |=> counter == $past(counter) - 16'h0001)
    else $error("timer step did not count down");

  // stopped counter holds
  stopped_hold_a: assert property (!start && !val_wr |=> $stable(counter))
    else $error("counter moved while halted");

  // halted write reaches counter and reload
  halted_write_a: assert property ((value_write_s and !start)
                                   |=> counter == $past(pwdata[15:0]) && reload == $past(pwdata[15:0]))
    else $error("halted write missed counter or reload");

  // running write waits for the next reload
  running_write_a: assert property ((value_write_s and start && !step)
                                    |=> counter == $past(counter) && reload == $past(pwdata[15:0]))
    else $error("running write touched the counter");

  // read snapshot is the live count
  value_read_a: assert property (rd_first && paddr == TMA_OFF_VALUE
                                 |=> prdata == {16'h0000, $past(counter)} && pready)
    else $error("read did not return counter");

  // level flips on wrap, reaches the pin a cycle later
  pulse_toggle_a: assert property (wrap && pulse_en && (op_mode != TMA_MD_ONESHOT) && !val_wr
                                   |=> pulse_lvl != $past(pulse_lvl) ##1 pulse_output_pin_out == $past(pulse_lvl))
    else $error("pulse output did not toggle on wrap");

  // halted one-shot keeps its zero
  oneshot_halt_a: assert property ((op_mode == TMA_MD_ONESHOT) && halted && !wr_en |=> $stable(counter))
    else $error("one-shot kept counting at zero");

  // free-run up count wraps to zero
  free_run_a: assert property ((op_mode == TMA_MD_EVENT) && free_run && wrap && up_step && !val_wr
                               |=> counter == TMA_CNT_ZERO)
    else $error("free-run up count did not wrap to zero");

  // every event wrap raises the request
  event_irq_a: assert property ((op_mode == TMA_MD_EVENT) && wrap |=> irq_req)
    else $error("no interrupt pulse on event wrap");

  // closed gate freezes the timer
  gate_block_a: assert property ((op_mode == TMA_MD_TIMER) && gate_en && (cin_s2 != gate_lvl) && !val_wr
                                 |=> $stable(counter))
    else $error("counter moved with gate closed");

  // pin used as direction input is never driven
  pin_release_a: assert property ((op_mode == TMA_MD_EVENT) && dir_pin |=> !pulse_output_pin_oe)
    else $error("shared pin driven while used as direction input");
endmodule

// [tma_pkg.sv]
// package of constants for the timer count unit: register map, field layout, mode codes, divider ratios.
// assumes a 32-bit apb slave with byte addresses and one word per register.
package tma_pkg;
  // register byte offsets
  localparam logic [11:0] TMA_OFF_VALUE = 12'h000;  // timer value: write reload, read counter
  localparam logic [11:0] TMA_OFF_MODE = 12'h004;  // mode and select functions
  localparam logic [11:0] TMA_OFF_CTRL = 12'h008;  // count start and software direction
  localparam logic [11:0] TMA_OFF_STAT = 12'h00c;  // live state, read only
  // mode register fields
  localparam int TMA_MODE_LSB = 0;  // two-bit operating mode
  localparam int TMA_PULSE_EN_BIT = 2;  // pulse output function
  localparam int TMA_GATE_EN_BIT = 3;  // gate function in timer mode
  localparam int TMA_GATE_LVL_BIT = 4;  // pin level that lets counting run
  localparam int TMA_EDGE_RISE_BIT = 5;  // event edge: 1 rising, 0 falling
  localparam int TMA_DIR_PIN_BIT = 6;  // direction taken from the output pin
  localparam int TMA_FREE_RUN_BIT = 7;  // no reload on wrap
  localparam int TMA_CLK_SEL_LSB = 8;  // internal source select, two bits
  localparam int TMA_EVT_SRC_LSB = 10;  // event source select, two bits
  localparam int TMA_MODE_W = 12;  // implemented mode bits
  // control register fields
  localparam int TMA_START_BIT = 0;  // count start flag
  localparam int TMA_UP_BIT = 1;  // software direction, 1 counts up
  // status register fields
  localparam int TMA_ST_PULSE_BIT = 0;  // pulse output level
  localparam int TMA_ST_RUN_BIT = 1;  // count step taken this cycle
  localparam int TMA_ST_HALT_BIT = 2;  // one-shot halted at zero
  localparam int TMA_ST_TWOPH_BIT = 3;  // instance owns two-phase capability
  // operating modes held in bits 1:0
  localparam logic [1:0] TMA_MD_TIMER = 2'h0;
  localparam logic [1:0] TMA_MD_EVENT = 2'h1;
  localparam logic [1:0] TMA_MD_ONESHOT = 2'h2;
  localparam logic [1:0] TMA_MD_PWM = 2'h3;
  // internal clock selections
  localparam logic [1:0] TMA_CS_F1 = 2'h0;
  localparam logic [1:0] TMA_CS_F8 = 2'h1;
  localparam logic [1:0] TMA_CS_F32 = 2'h2;
  localparam logic [1:0] TMA_CS_FC32 = 2'h3;
  // event sources
  localparam logic [1:0] TMA_ES_PIN = 2'h0;
  localparam logic [1:0] TMA_ES_COMP_B = 2'h1;
  localparam logic [1:0] TMA_ES_NEIGH_A = 2'h2;
  // divider ratios and reset values
  localparam int TMA_DIV8 = 8;
  localparam int TMA_DIV32 = 32;
  localparam int TMA_TWO_PHASE_MIN_INST = 2;  // instances from here upward have two-phase
  localparam logic [15:0] TMA_CNT_RST = 16'h0000;
  localparam logic [15:0] TMA_CNT_MAX = 16'hffff;
  localparam logic [15:0] TMA_CNT_ZERO = 16'h0000;
  localparam logic [TMA_MODE_W-1:0] TMA_MODE_RST = 12'h000;
  localparam logic [31:0] TMA_WORD_ZERO = 32'h00000000;
endpackage

// [tma_prescale.sv]
// prescaler for the timer count unit: one-cycle enables at f1, f/8, f/32 and sub-clock/32.
// assumes sub_tick is already a synchronised one-cycle pulse per sub-clock period.
`timescale 1ns/100ps
module tma_prescale (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sub_tick,
  input wire logic [1:0] sel,
  output logic tick
);
  import tma_pkg::*;

  logic [4:0] div_main;  // free-running main divider
  logic [4:0] div_sub;  // sub-clock divider

  // main divider runs always so the f8 and f32 phases stay fixed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_main <= 5'h00;
    end else begin
      div_main <= div_main + 5'h01;
    end
  end

  // sub-clock divider advances only on sub-clock edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_sub <= 5'h00;
    end else if (sub_tick) begin
      div_sub <= div_sub + 5'h01;
    end
  end

  // selected enable, registered so the counter sees a clean pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 1'b0;
    end else begin
      unique case (sel)
        TMA_CS_F1: tick <= 1'b1;
        TMA_CS_F8: tick <= (div_main[2:0] == 3'(TMA_DIV8 - 1));
        TMA_CS_F32: tick <= (div_main == 5'(TMA_DIV32 - 1));
        TMA_CS_FC32: tick <= sub_tick && (div_sub == 5'(TMA_DIV32 - 1));
      endcase
    end
  end
endmodule

// [tma_pulse_src.sv]
// partner model for the timer count unit: count input, free sub-clock, overflow pulses, direction level.
// assumes it shares pclk with the unit and is steered by the bench through its tasks.
`timescale 1ns/100ps
module tma_pulse_src (
  input wire logic pclk,
  input wire logic pin_oe,
  input wire logic pin_out,
  output logic count_input_pin,
  output logic sub_clock_pin,
  output logic companion_b_timer_ovf,
  output logic neighbour_a_timer_ovf,
  output logic pulse_output_pin_in
);
  logic dir_lvl;  // level put on the shared pin while the unit leaves it undriven
  // shared pin follows the unit while it drives, else the external direction level
  assign pulse_output_pin_in = pin_oe ? pin_out : dir_lvl;
  initial begin
    count_input_pin = 1'b0;
    sub_clock_pin = 1'b0;
    companion_b_timer_ovf = 1'b0;
    neighbour_a_timer_ovf = 1'b0;
    dir_lvl = 1'b0;
  end
  // a sub-clock oscillator runs free: eight pclk cycles a period
  always begin
    repeat (4) @(posedge pclk);
    sub_clock_pin <= ~sub_clock_pin;
  end
  // full pulses, four cycles high and four low, so both edges occur and survive synchronising
  task pin_pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      count_input_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      count_input_pin <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
  // steady level on the count input, used as the gate
  task set_level(input logic lvl);
    @(posedge pclk);
    count_input_pin <= lvl;
  endtask
  // overflow pulses on every cycle, the hardest spacing a neighbour timer can give
  task ovf_pulses(input logic from_b, input int n);
    repeat (n) begin
      @(posedge pclk);
      companion_b_timer_ovf <= from_b;
      neighbour_a_timer_ovf <= ~from_b;
    end
    @(posedge pclk);
    companion_b_timer_ovf <= 1'b0;
    neighbour_a_timer_ovf <= 1'b0;
  endtask
  task set_dir(input logic up);
    @(posedge pclk);
    dir_lvl <= up;
  endtask
endmodule

// [timer_a_count_unit_tb_top.sv]
// self-checking bench for the timer count unit: apb register access, timer, gate, event and one-shot runs.
// assumes the partner model drives the pins and that the apb slave answers with one wait state.
`timescale 1ns/100ps
module timer_a_count_unit_tb_top;
  import tma_pkg::*;
  localparam logic [5:0] PUL = 6'h01, GAT = 6'h02, GLV = 6'h04, RIS = 6'h08, DRP = 6'h10, FRE = 6'h20;
  localparam logic [31:0] GO = 32'h1 << TMA_START_BIT;  // count start flag
  localparam logic [31:0] UPB = 32'h1 << TMA_UP_BIT;  // software up direction
  localparam int SUB_PER = 8;  // sub-clock period in pclk cycles, set by the model
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_pulse, pslverr_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic cnt_pin, sub_pin, ovf_b, ovf_a, dir_in, p_out, p_oe, irq_req;
  int n_fail, num_checks, cyc, irq_cnt, tog_cnt, g;
  tma_count_unit #(.INST_ID(0)) u_tma_count_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_input_pin(cnt_pin), .sub_clock_pin(sub_pin), .companion_b_timer_ovf(ovf_b),
    .neighbour_a_timer_ovf(ovf_a), .pulse_output_pin_in(dir_in), .pulse_output_pin_out(p_out),
    .pulse_output_pin_oe(p_oe), .irq_req(irq_req));
  tma_pulse_src u_tma_pulse_src (.pclk(pclk), .pin_oe(p_oe), .pin_out(p_out), .count_input_pin(cnt_pin),
    .sub_clock_pin(sub_pin), .companion_b_timer_ovf(ovf_b), .neighbour_a_timer_ovf(ovf_a),
    .pulse_output_pin_in(dir_in));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // monitor: counts interrupt pulses and pulse-pin toggles, and cuts a hang short
  always @(posedge pclk) begin
    cyc++;
    if (irq_req === 1'b1) irq_cnt++;
    if (p_out !== last_pulse) tog_cnt++;
    last_pulse <= p_out;
    if (cyc >= 40000) begin
      n_fail++;
      conclude();
    end
  end
  task conclude();
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high at a rising edge
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait as long as it takes; only the cycle ceiling ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  task rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    apb(a, 1'b0, 32'h0, d, e);
  endtask
  function automatic logic [31:0] mw(input logic [1:0] md, input logic [1:0] cs, input logic [1:0] es,
    input logic [5:0] f);
    logic [31:0] m;
    m = 32'h0;
    m[TMA_MODE_LSB +: 2] = md;
    m[TMA_PULSE_EN_BIT] = f[0];
    m[TMA_GATE_EN_BIT] = f[1];
    m[TMA_GATE_LVL_BIT] = f[2];
    m[TMA_EDGE_RISE_BIT] = f[3];
    m[TMA_DIR_PIN_BIT] = f[4];
    m[TMA_FREE_RUN_BIT] = f[5];
    m[TMA_CLK_SEL_LSB +: 2] = cs;
    m[TMA_EVT_SRC_LSB +: 2] = es;
    return m;
  endfunction
  // halt, program mode and value, confirm the halted write reached the counter, then start
  task setup(input logic [31:0] m, input logic [15:0] n, input logic [31:0] c);
    wr(TMA_OFF_CTRL, 32'h0);
    wr(TMA_OFF_MODE, m);
    wr(TMA_OFF_VALUE, {16'h0, n});
    rd(TMA_OFF_VALUE, v);
    chk(v, {16'h0, n}, "halted write");
    irq_cnt = 0;
    tog_cnt = 0;
    wr(TMA_OFF_CTRL, c);
  endtask
  // cycles between two successive interrupt pulses; the first wait is bounded as well
  task gap(output int n);
    int k;
    k = 0;
    while (irq_req !== 1'b1 && k < 5000) begin
      @(posedge pclk);
      k++;
    end
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (irq_req !== 1'b1 && n < 5000);
  endtask
  task halt();
    wr(TMA_OFF_CTRL, 32'h0);
    repeat (4) @(posedge pclk);
  endtask
  task t_reset();
    rd(TMA_OFF_VALUE, v);
    chk(v, 32'h0, "value after reset");
    rd(TMA_OFF_MODE, v);
    chk(v, 32'h0, "mode after reset");
    rd(TMA_OFF_STAT, v);
    chk({31'h0, v[TMA_ST_TWOPH_BIT]}, 32'h0, "two-phase on instance 0");
    wr(12'h010, 32'h1234);
    apb(12'h010, 1'b0, 32'h0, v, pslverr_seen);
    chk(v, 32'h0, "unmapped read data");
    chk({31'h0, pslverr_seen}, 32'h1, "unmapped error");
  endtask
  // timer mode at n=2, f1: period, interrupt and pulse toggle, then a clean stop
  task t_timer();
    logic [31:0] a;
    setup(mw(TMA_MD_TIMER, TMA_CS_F1, TMA_ES_PIN, PUL), 16'h2, GO);
    gap(g);
    gap(g);
    chk(32'(g), 32'd3, "timer period");
    chk({31'h0, p_oe}, 32'h1, "pulse pin driven");
    halt();
    chk(32'(tog_cnt), 32'(irq_cnt), "toggle per underflow");
    g = irq_cnt;
    rd(TMA_OFF_VALUE, a);
    repeat (10) @(posedge pclk);
    rd(TMA_OFF_VALUE, v);
    chk(v, a, "stopped counter holds");
    chk(32'(irq_cnt), 32'(g), "no interrupt while stopped");
  endtask
  task t_sources();
    int dv[4];
    dv = '{1, TMA_DIV8, TMA_DIV32, TMA_DIV32 * SUB_PER};
    for (int cs = 0; cs < 4; cs++) begin
      setup(mw(TMA_MD_TIMER, 2'(cs), TMA_ES_PIN, 6'h0), 16'h1, GO);
      gap(g);
      gap(g);
      chk(32'(g), 32'(2 * dv[cs]), "source period");
    end
    halt();
  endtask
  task t_write_running();
    // long first period so no wrap falls between the write and the read
    setup(mw(TMA_MD_TIMER, TMA_CS_F1, TMA_ES_PIN, 6'h0), 16'h40, GO);
    wr(TMA_OFF_VALUE, 32'h5);
    rd(TMA_OFF_VALUE, v);
    chk({31'h0, (v > 32'h5 && v <= 32'h40)}, 32'h1, "counter kept on running write");
    gap(g);
    gap(g);
    chk(32'(g), 32'd6, "period after reload");
    halt();
  endtask
  task t_gate();
    u_tma_pulse_src.set_level(1'b0);
    setup(mw(TMA_MD_TIMER, TMA_CS_F1, TMA_ES_PIN, GAT | GLV), 16'h2, GO);
    repeat (20) @(posedge pclk);
    chk(32'(irq_cnt), 32'h0, "gate closed");
    u_tma_pulse_src.set_level(1'b1);
    gap(g);
    gap(g);
    chk(32'(g), 32'd3, "gate open period");
    halt();
    u_tma_pulse_src.set_level(1'b0);
  endtask
  // every event source in both directions; six events give two wraps at period three
  task t_events();
    logic [1:0] srcs[3];
    logic [15:0] n;
    srcs = '{TMA_ES_PIN, TMA_ES_COMP_B, TMA_ES_NEIGH_A};
    for (int s = 0; s < 3; s++) begin
      for (int up = 0; up < 2; up++) begin
        n = (up == 1) ? 16'hfffd : 16'h0002;
        setup(mw(TMA_MD_EVENT, TMA_CS_F1, srcs[s], PUL | (up == 1 ? RIS : 6'h0)), n, GO | (up == 1 ? UPB : 32'h0));
        if (s == 0) u_tma_pulse_src.pin_pulses(6);
        else u_tma_pulse_src.ovf_pulses(s == 1, 6);
        repeat (10) @(posedge pclk);
        halt();
        chk(32'(irq_cnt), 32'h2, "event wraps");
        chk(32'(tog_cnt), 32'h2, "event toggles");
        rd(TMA_OFF_VALUE, v);
        chk(v, {16'h0, n}, "event reload");
      end
    end
  endtask
  task t_free_dir();
    setup(mw(TMA_MD_EVENT, TMA_CS_F1, TMA_ES_PIN, RIS | FRE), 16'h2, GO);
    u_tma_pulse_src.pin_pulses(3);
    repeat (10) @(posedge pclk);
    halt();
    chk(32'(irq_cnt), 32'h1, "free-run wrap");
    rd(TMA_OFF_VALUE, v);
    chk(v, 32'hffff, "free-run no reload");
    setup(mw(TMA_MD_EVENT, TMA_CS_F1, TMA_ES_PIN, RIS | FRE), 16'hfffe, GO | UPB);
    u_tma_pulse_src.pin_pulses(3);
    repeat (10) @(posedge pclk);
    halt();
    chk(32'(irq_cnt), 32'h1, "free-run up wrap");
    rd(TMA_OFF_VALUE, v);
    chk(v, 32'h1, "free-run up no reload");
    u_tma_pulse_src.set_dir(1'b1);
    // pulse output enabled too, so only the direction choice can release the pin
    setup(mw(TMA_MD_EVENT, TMA_CS_F1, TMA_ES_PIN, RIS | DRP | PUL), 16'hfffe, GO);
    chk({31'h0, p_oe}, 32'h0, "pin released as input");
    u_tma_pulse_src.pin_pulses(2);
    repeat (10) @(posedge pclk);
    halt();
    chk(32'(irq_cnt), 32'h1, "pin direction up");
    rd(TMA_OFF_VALUE, v);
    chk(v, 32'hfffe, "pin direction reload");
  endtask
  task t_oneshot();
    setup(mw(TMA_MD_ONESHOT, TMA_CS_F1, TMA_ES_PIN, 6'h0), 16'h3, GO);
    repeat (30) @(posedge pclk);
    rd(TMA_OFF_VALUE, v);
    chk(v, 32'h0, "one-shot halts at zero");
    setup(mw(TMA_MD_PWM, TMA_CS_F1, TMA_ES_PIN, 6'h0), 16'h3, GO);
    repeat (30) @(posedge pclk);
    rd(TMA_OFF_VALUE, v);
    chk(v, 32'h3, "pwm code does not count");
    halt();
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {n_fail, num_checks, cyc, irq_cnt, tog_cnt} = '0;
    last_pulse = 1'b0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_timer();
    t_sources();
    t_write_running();
    t_gate();
    t_events();
    t_free_dir();
    t_oneshot();
    conclude();
  end
endmodule
